// [verilog/fik_gate.sv]
/*
 Flash programming key gate: register file, key window, boot call
 acceptance, per-byte flash sequencing, interrupt hold-off, watchdog.
 Assumes a flash array on the user side that answers fl_req with fl_ack
 on the same clock, and a core that keeps its own rules on the link.
*/
`timescale 1ns/1ns
module fik_gate
  import fik_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  fik_if.gate              lnk,
  input  wire logic        security_bit,
  input  wire logic [7:0]  option_value,
  input  wire logic [3:0]  irq_src,
  output logic             fl_req,
  output fik_cmd_type      fl_op,
  output logic [15:0]      fl_addr,
  output logic [7:0]       fl_wdata,
  output logic [7:0]       fl_timing,
  input  wire logic [7:0]  fl_rdata,
  input  wire logic        fl_ack,
  output logic             wdog_service,
  output logic             wdog_lower_en
);
  typedef enum {G_IDLE, G_ISSUE, G_WAIT, G_DONE} fik_gate_state_type;

  fik_gate_state_type state_r;
  logic [7:0]  addr_lo_r, addr_hi_r, rd_data_r, wr_data_r, timing_r, count_r;
  logic [2:0]  key_cnt_r;
  logic [3:0]  pend_r;
  logic [1:0]  sec_sync_r;
  logic [11:0] wdog_cnt_r;
  logic [7:0]  remain_r, ptr_r, rdata_r;
  fik_cmd_type op_r;
  logic        busy_r, refused_r, take_r, ram_we_r;
  logic        fl_req_r, wdog_svc_r, lower_en_r;
  logic [7:0]  ram_wdata_r, fl_wdata_r;

  // Decode of link accesses
  wire key_write   = lnk.reg_we && lnk.reg_addr == OFS_UNLOCK;
  wire key_good    = lnk.reg_wdata == KEY_VALUE;
  wire key_live    = key_cnt_r != 3'h0 && !take_r;
  wire sec_on      = sec_sync_r[1];
  wire loader_ok   = lnk.call_cmd inside {FIK_MASS_ERASE, FIK_WR_TIMING, FIK_RD_OPTION};
  wire sec_block   = lnk.from_loader && sec_on && !loader_ok;
  wire mass_bad    = lnk.call_cmd == FIK_MASS_ERASE && lnk.acc != MASS_CONFIRM;
  wire [5:0] span  = 6'(addr_lo_r[4:0]) + 6'(count_r[4:0]);
  wire blk_bad     = lnk.call_cmd == FIK_BLOCK_WRITE &&
                     (count_r > BLOCK_WR_MAX || span > HALF_PAGE_BYTES);
  wire call_seen   = lnk.call && state_r == G_IDLE;
  wire call_ok     = call_seen && key_live && !sec_block && !mass_bad && !blk_bad;
  wire is_block    = op_r == FIK_BLOCK_READ || op_r == FIK_BLOCK_WRITE;
  wire last_byte   = !is_block || remain_r == 8'h01;
  wire [15:0] cur_addr = {addr_hi_r, addr_lo_r};
  wire [15:0] nxt_addr = cur_addr + 16'h0001;
  wire [3:0]  low_pend = pend_r & (~pend_r + 4'h1);
  wire deliver     = !busy_r && lnk.global_irq_enable && pend_r != 4'h0;
  wire reg_hit_we  = lnk.reg_we && !busy_r;

  // Register file, written by the core or updated by the sequencer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      addr_lo_r <= REG_RESET;
      addr_hi_r <= REG_RESET;
      rd_data_r <= REG_RESET;
      wr_data_r <= REG_RESET;
      timing_r  <= REG_RESET;
      count_r   <= REG_RESET;
    end else if (reg_hit_we) begin
      unique case (lnk.reg_addr)
        OFS_ADDR_LOW:   addr_lo_r <= lnk.reg_wdata;
        OFS_ADDR_HIGH:  addr_hi_r <= lnk.reg_wdata;
        OFS_READ_DATA:  rd_data_r <= lnk.reg_wdata;
        OFS_WRITE_DATA: wr_data_r <= lnk.reg_wdata;
        OFS_TIMING:     timing_r  <= lnk.reg_wdata;
        OFS_BYTE_COUNT: count_r   <= lnk.reg_wdata;
        default:        ;
      endcase
    end else if (call_ok && lnk.call_cmd == FIK_WR_TIMING) begin
      timing_r <= lnk.acc;
    end else if (call_ok && lnk.call_cmd == FIK_RD_OPTION) begin
      rd_data_r <= option_value;
    end else if (state_r == G_WAIT && fl_ack) begin
      if (op_r == FIK_READ_BYTE || op_r == FIK_BLOCK_READ)
        rd_data_r <= fl_rdata;
      if (is_block) begin
        addr_lo_r <= nxt_addr[7:0];
        addr_hi_r <= nxt_addr[15:8];
      end
    end
  end

  // Read-back mux, one cycle behind the address
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_r <= REG_RESET;
    end else begin
      unique case (lnk.reg_addr)
        OFS_ADDR_LOW:   rdata_r <= addr_lo_r;
        OFS_ADDR_HIGH:  rdata_r <= addr_hi_r;
        OFS_READ_DATA:  rdata_r <= rd_data_r;
        OFS_WRITE_DATA: rdata_r <= wr_data_r;
        OFS_TIMING:     rdata_r <= timing_r;
        OFS_BYTE_COUNT: rdata_r <= count_r;
        default:        rdata_r <= REG_RESET;
      endcase
    end
  end

  // Key window; a wrong value, or a call in G_IDLE with no key write, empties it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      key_cnt_r <= 3'h0;
    end else if (key_write) begin
      key_cnt_r <= key_good ? KEY_WINDOW_CYC : 3'h0;
    end else if (call_seen || take_r) begin
      key_cnt_r <= 3'h0;
    end else if (key_cnt_r != 3'h0) begin
      key_cnt_r <= key_cnt_r - 3'h1;
    end
  end

  // Security level comes from a pin
  always_ff @(posedge clk) begin
    if (!nrst)
      sec_sync_r <= 2'b00;
    else
      sec_sync_r <= {sec_sync_r[0], security_bit};
  end

  // Interrupts: a source already pending drops repeats
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend_r <= 4'h0;
      take_r <= 1'b0;
    end else begin
      pend_r <= (pend_r & ~(deliver ? low_pend : 4'h0)) | irq_src;
      take_r <= deliver;
    end
  end

  // Sequencer; data-only commands finish at the call itself
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r    <= G_IDLE;
      op_r       <= FIK_READ_BYTE;
      busy_r     <= 1'b0;
      refused_r  <= 1'b0;
      remain_r   <= 8'h00;
      ptr_r      <= 8'h00;
      fl_req_r   <= 1'b0;
      fl_wdata_r <= 8'h00;
      ram_we_r   <= 1'b0;
      ram_wdata_r <= 8'h00;
    end else begin
      refused_r <= call_seen && !call_ok;
      ram_we_r  <= 1'b0;
      unique case (state_r)
        G_IDLE: if (call_ok) begin
          op_r     <= lnk.call_cmd;
          busy_r   <= 1'b1;
          remain_r <= count_r;
          ptr_r    <= 8'h00;
          state_r  <= lnk.call_cmd inside {FIK_WR_TIMING, FIK_RD_OPTION} ? G_DONE : G_ISSUE;
        end
        G_ISSUE: if (is_block && remain_r == 8'h00) begin
          state_r <= G_DONE;
        end else begin
          fl_req_r   <= 1'b1;
          fl_wdata_r <= op_r == FIK_BLOCK_WRITE ? lnk.ram_rdata : wr_data_r;
          state_r    <= G_WAIT;
        end
        G_WAIT: if (fl_ack) begin
          fl_req_r    <= 1'b0;
          ram_we_r    <= op_r == FIK_BLOCK_READ;
          ram_wdata_r <= fl_rdata;
          remain_r    <= remain_r - 8'h01;
          state_r     <= last_byte ? G_DONE : G_ISSUE;
        end
        G_DONE: begin
          busy_r  <= 1'b0;
          state_r <= G_IDLE;
        end
      endcase
      // Read steps after its buffer write lands, so byte n fills slot n
      if (ram_we_r || (state_r == G_WAIT && fl_ack && op_r == FIK_BLOCK_WRITE))
        ptr_r <= ptr_r + 8'h01;
    end
  end

  // Watchdog kept alive inside its window and on return
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wdog_cnt_r <= 12'h000;
      wdog_svc_r <= 1'b0;
      lower_en_r <= 1'b0;
    end else begin
      wdog_svc_r <= (busy_r && wdog_cnt_r == WDOG_SERVICE_CYC - 12'h001) ||
                    state_r == G_DONE;
      wdog_cnt_r <= busy_r && wdog_cnt_r != WDOG_SERVICE_CYC - 12'h001 ?
                    wdog_cnt_r + 12'h001 : 12'h000;
      if (state_r == G_DONE)
        lower_en_r <= 1'b1;
    end
  end

  assign lnk.reg_rdata = rdata_r;
  assign lnk.busy      = busy_r;
  assign lnk.refused   = refused_r;
  assign lnk.irq_take  = take_r;
  assign lnk.ram_ptr   = ptr_r;
  assign lnk.ram_we    = ram_we_r;
  assign lnk.ram_wdata = ram_wdata_r;
  assign fl_req        = fl_req_r;
  assign fl_op         = op_r;
  assign fl_addr       = cur_addr;
  assign fl_wdata      = fl_wdata_r;
  assign fl_timing     = timing_r;
  assign wdog_service  = wdog_svc_r;
  assign wdog_lower_en = lower_en_r;
endmodule : fik_gate

// [common/fik_pkg.sv]
/*
 Shared constants and types for the flash programming key gate:
 core-side register offsets, key and confirmation values, command codes,
 timing counts and the controller's own APB register map.
 Assumes one 10 MHz clock, one instruction cycle per clock.
*/
package fik_pkg;
  // Core-side register offsets
  localparam logic [7:0] OFS_ADDR_LOW    = 8'ha8;
  localparam logic [7:0] OFS_ADDR_HIGH   = 8'ha9;
  localparam logic [7:0] OFS_READ_DATA   = 8'haa;
  localparam logic [7:0] OFS_WRITE_DATA  = 8'hab;
  localparam logic [7:0] OFS_TIMING      = 8'he1;
  localparam logic [7:0] OFS_UNLOCK      = 8'he2;
  localparam logic [7:0] OFS_BYTE_COUNT  = 8'hf1;
  localparam logic [7:0] KEY_VALUE       = 8'h98;
  localparam logic [7:0] MASS_CONFIRM    = 8'h55;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [7:0] BLOCK_WR_MAX    = 8'h10;
  localparam logic [5:0] HALF_PAGE_BYTES = 6'h20;
  // Timing values, in ns or in instruction cycles of 100 ns
  localparam int         CLK_PERIOD_NS   = 100;
  localparam logic [2:0] KEY_WINDOW_CYC  = 3'h6;
  localparam int         WDOG_SERVICE_NS = 100000;
  localparam logic [11:0] WDOG_SERVICE_CYC = 12'(WDOG_SERVICE_NS / CLK_PERIOD_NS);
  // Controller APB map, one word each except APB_BUF, which spans 16 words
  localparam logic [7:0] APB_CTRL        = 8'h00;
  localparam logic [7:0] APB_ADDR        = 8'h04;
  localparam logic [7:0] APB_WDATA       = 8'h08;
  localparam logic [7:0] APB_COUNT       = 8'h0c;
  localparam logic [7:0] APB_TIMING      = 8'h10;
  localparam logic [7:0] APB_STATUS      = 8'h14;
  localparam logic [7:0] APB_GIE         = 8'h18;
  localparam logic [7:0] APB_BUF         = 8'h40;
  localparam int         STAT_BUSY       = 0;
  localparam int         STAT_DONE       = 1;
  localparam int         STAT_REFUSED    = 2;

  typedef enum logic [2:0] {
    FIK_READ_BYTE, FIK_WRITE_BYTE, FIK_BLOCK_READ, FIK_BLOCK_WRITE,
    FIK_PAGE_ERASE, FIK_MASS_ERASE, FIK_WR_TIMING, FIK_RD_OPTION
  } fik_cmd_type;
endpackage : fik_pkg

// [common/fik_if.sv]
/*
 Link between the core-side controller and the key gate.
 Assumes both ends run on the same clk; no clocking block.
*/
`timescale 1ns/1ns
interface fik_if (input wire logic clk);
  import fik_pkg::*;
  logic        reg_we;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        call;
  fik_cmd_type call_cmd;
  logic [7:0]  acc;
  logic        from_loader;
  logic        global_irq_enable;
  logic        busy;
  logic        refused;
  logic        irq_take;
  logic [7:0]  ram_ptr;
  logic        ram_we;
  logic [7:0]  ram_wdata;
  logic [7:0]  ram_rdata;

  modport gate (input reg_we, reg_addr, reg_wdata, call, call_cmd, acc, from_loader, global_irq_enable,
                ram_rdata,
                output reg_rdata, busy, refused, irq_take, ram_ptr, ram_we, ram_wdata);
  modport core (output reg_we, reg_addr, reg_wdata, call, call_cmd, acc, from_loader, global_irq_enable,
                ram_rdata,
                input reg_rdata, busy, refused, irq_take, ram_ptr, ram_we, ram_wdata);
endinterface : fik_if

// [verilog/fik_core.sv]
/*
 Core-side controller: APB slave registers and a sequencer that loads
 the gate registers, writes the key, calls at once and collects results.
 Assumes an APB master on the same clock and the gate on the link.
*/
`timescale 1ns/1ns
module fik_core
  import fik_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  fik_if.core              lnk,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  typedef enum {C_IDLE, C_LOAD, C_CALL, C_WAIT, C_RD, C_CAP} fik_core_state_type;

  fik_core_state_type state_r;
  logic [15:0] addr_r;
  logic [7:0]  wdata_r, count_r, timing_r, acc_r, result_r, irq_cnt_r;
  fik_cmd_type cmd_r;
  logic        loader_r, gie_r, done_r, refd_r, busy_r, seen_busy_r;
  logic [2:0]  idx_r;
  logic [7:0]  buf_r [16];
  logic [31:0] prdata_r;
  logic        slverr_r, pready_r;
  logic        we_r;
  logic [7:0]  waddr_r, wval_r;

  wire setup   = psel && !penable;
  wire wr_acc  = psel && penable && pwrite;
  wire buf_hit = paddr[7:6] == APB_BUF[7:6];
  wire mapped  = buf_hit || paddr inside {APB_CTRL, APB_ADDR, APB_WDATA, APB_COUNT,
                                          APB_TIMING, APB_STATUS, APB_GIE};
  wire go      = wr_acc && paddr == APB_CTRL && state_r == C_IDLE;
  wire clr     = wr_acc && paddr == APB_STATUS;
  wire [31:0] status = {8'h00, result_r, irq_cnt_r, 5'h00, refd_r, done_r, busy_r};

  function automatic logic [15:0] load_word(input logic [2:0] i);
    unique case (i)
      3'h0:    load_word = {OFS_ADDR_LOW, addr_r[7:0]};
      3'h1:    load_word = {OFS_ADDR_HIGH, addr_r[15:8]};
      3'h2:    load_word = {OFS_WRITE_DATA, wdata_r};
      3'h3:    load_word = {OFS_BYTE_COUNT, count_r};
      3'h4:    load_word = {OFS_TIMING, timing_r};
      default: load_word = {OFS_UNLOCK, KEY_VALUE};
    endcase
  endfunction : load_word

  // APB registers; zero wait states, error on unmapped words
  always_ff @(posedge clk) begin
    if (!nrst) begin
      addr_r   <= 16'h0000;
      wdata_r  <= 8'h00;
      count_r  <= 8'h00;
      timing_r <= 8'h00;
      gie_r    <= 1'b0;
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
      pready_r <= 1'b0;
    end else begin
      pready_r <= 1'b1;
      if (setup) begin
        slverr_r <= !mapped;
        prdata_r <= paddr == APB_STATUS ? status :
                    paddr == APB_GIE ? {31'h0, gie_r} :
                    buf_hit ? {24'h0, buf_r[paddr[5:2]]} : 32'h0000_0000;
      end
      if (wr_acc) begin
        unique case (paddr)
          APB_ADDR:   addr_r   <= pwdata[15:0];
          APB_WDATA:  wdata_r  <= pwdata[7:0];
          APB_COUNT:  count_r  <= pwdata[7:0];
          APB_TIMING: timing_r <= pwdata[7:0];
          APB_GIE:    gie_r    <= pwdata[0];
          default:    ;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (wr_acc && buf_hit)
      buf_r[paddr[5:2]] <= pwdata[7:0];
    else if (lnk.ram_we)
      buf_r[lnk.ram_ptr[3:0]] <= lnk.ram_wdata;
  end

  // Sequencer; interrupts masked from the APB_CTRL write until return
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= C_IDLE;
      cmd_r <= FIK_READ_BYTE;
      acc_r <= 8'h00;
      loader_r <= 1'b0;
      idx_r <= 3'h0;
      busy_r <= 1'b0;
      seen_busy_r <= 1'b0;
      done_r <= 1'b0;
      refd_r <= 1'b0;
      result_r <= 8'h00;
      irq_cnt_r <= 8'h00;
      we_r <= 1'b0;
      waddr_r <= 8'h00;
      wval_r <= 8'h00;
    end else begin
      we_r <= 1'b0;
      irq_cnt_r <= irq_cnt_r + 8'(lnk.irq_take);
      if (clr) begin
        done_r <= done_r & ~pwdata[STAT_DONE];
        refd_r <= refd_r & ~pwdata[STAT_REFUSED];
      end
      unique case (state_r)
        C_IDLE: if (go) begin
          cmd_r <= fik_cmd_type'(pwdata[2:0]);
          loader_r <= pwdata[3];
          acc_r <= pwdata[15:8];
          busy_r <= 1'b1;
          idx_r <= 3'h0;
          state_r <= C_LOAD;
        end
        C_LOAD: begin
          // Key must land one cycle before the call, never with it
          we_r <= idx_r != 3'h6;
          {waddr_r, wval_r} <= load_word(idx_r);
          idx_r <= idx_r + 3'h1;
          if (idx_r == 3'h6)
            state_r <= C_CALL;
        end
        C_CALL: begin
          seen_busy_r <= 1'b0;
          state_r <= C_WAIT;
        end
        C_WAIT: if (lnk.refused) begin
          refd_r <= 1'b1;
          busy_r <= 1'b0;
          state_r <= C_IDLE;
        end else if (lnk.busy) begin
          seen_busy_r <= 1'b1;
        end else if (seen_busy_r) begin
          waddr_r <= OFS_READ_DATA;
          state_r <= C_RD;
        end
        C_RD: state_r <= C_CAP;
        C_CAP: begin
          result_r <= lnk.reg_rdata;
          done_r <= 1'b1;
          busy_r <= 1'b0;
          state_r <= C_IDLE;
        end
      endcase
    end
  end

  assign lnk.reg_we    = we_r;
  assign lnk.reg_addr  = waddr_r;
  assign lnk.reg_wdata = wval_r;
  assign lnk.call      = state_r == C_CALL;
  assign lnk.call_cmd  = cmd_r;
  assign lnk.acc       = acc_r;
  assign lnk.from_loader = loader_r;
  assign lnk.global_irq_enable       = gie_r && !busy_r;
  assign lnk.ram_rdata = buf_r[lnk.ram_ptr[3:0]];
  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = slverr_r;
endmodule : fik_core

// [test/fik_checker.sv]
/*
 Concurrent checks on the link between the core controller and the key gate.
 Assumes one clock domain; the bench instantiates it beside the link.
*/
`timescale 1ns/1ns
module fik_checker
  import fik_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        reg_we,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        call,
  input wire fik_cmd_type call_cmd,
  input wire logic [7:0]  acc,
  input wire logic        from_loader,
  input wire logic        global_irq_enable,
  input wire logic        busy,
  input wire logic        refused,
  input wire logic        irq_take
);
  logic [2:0] key_age_r;
  logic       key_ok_r;
  logic [7:0] count_r;
  logic [7:0] addr_lo_r;
  wire        idle_we  = reg_we && !busy;
  wire        key_wr   = idle_we && reg_addr == OFS_UNLOCK;
  wire        key_live = key_ok_r && key_age_r < KEY_WINDOW_CYC;
  wire [8:0]  span     = {4'h0, addr_lo_r[4:0]} + {1'b0, count_r};
  wire [8:0]  half     = {3'h0, HALF_PAGE_BYTES};

  // Age saturates so a stale key never wraps back into the window
  always_ff @(posedge clk) begin
    if (!nrst) begin
      key_ok_r  <= 1'b0;
      key_age_r <= 3'h7;
    end else if (key_wr) begin
      key_ok_r  <= reg_wdata == KEY_VALUE;
      key_age_r <= 3'h0;
    end else begin
      key_ok_r  <= key_ok_r && !call && !irq_take;
      key_age_r <= key_age_r + {2'h0, key_age_r != 3'h7};
    end
  end
  always_ff @(posedge clk) begin
    if (idle_we && reg_addr == OFS_BYTE_COUNT) count_r <= reg_wdata;
    if (idle_we && reg_addr == OFS_ADDR_LOW) addr_lo_r <= reg_wdata;
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence call_taken;
    call && !busy;
  endsequence
  sequence refusal;
    refused && !busy;
  endsequence
  sequence stale_call;
    call_taken ##0 (!from_loader && !key_live);
  endsequence
  sequence live_read_call;
    call_taken ##0 (key_live && !from_loader && call_cmd == FIK_READ_BYTE);
  endsequence
  sequence unconfirmed_erase;
    call_taken ##0 (call_cmd == FIK_MASS_ERASE && acc != MASS_CONFIRM);
  endsequence
  sequence long_block;
    call_taken ##0 (call_cmd == FIK_BLOCK_WRITE && count_r > BLOCK_WR_MAX);
  endsequence
  sequence crossing_block;
    call_taken ##0 (call_cmd == FIK_BLOCK_WRITE && span > half);
  endsequence

  call_answer_a: assert property (call_taken |=> busy != refused)
    else $error("call not answered");
  stale_key_a: assert property (stale_call |=> refusal)
    else $error("call without live key accepted");
  accept_live_a: assert property (live_read_call |=> busy)
    else $error("keyed firmware read refused");
  mass_confirm_a: assert property (unconfirmed_erase |=> refusal)
    else $error("mass erase without confirmation");
  block_count_a: assert property (long_block |=> refusal)
    else $error("oversized block write accepted");
  half_page_a: assert property (crossing_block |=> refusal)
    else $error("block write crosses half page");
  irq_hold_a: assert property (busy |-> !irq_take)
    else $error("interrupt during programming");
  irq_gie_a: assert property (irq_take |-> global_irq_enable || $past(global_irq_enable))
    else $error("interrupt with global enable clear");
endmodule : fik_checker

// [test/flash_isp_key_gate_bench.sv]
/*
 Bench for the key gate: core and gate joined on one link and driven over
 APB, plus a second gate whose link the bench drives to break the key rules.
 Assumes the flash answers each request in the same cycle.
*/
`timescale 1ns/1ns
module flash_isp_key_gate_bench;
  import fik_pkg::*;
  typedef struct packed {
    fik_cmd_type cmd;
    logic        ldr;
    logic        sec;
    logic [15:0] addr;
    logic [7:0]  wd;
    logic [7:0]  cnt;
    logic        refd;
    logic [7:0]  rd;
  } fik_row_type;
  // wd doubles as the accumulator; rd of zero means no read-back check
  localparam fik_row_type ROWS [13] = '{
    '{FIK_WRITE_BYTE,1'b0,1'b0,16'h0012,8'h5a,8'h00,1'b0,8'h00},
    '{FIK_WRITE_BYTE,1'b0,1'b0,16'h0112,8'ha5,8'h00,1'b0,8'h00},
    '{FIK_READ_BYTE,1'b0,1'b0,16'h0012,8'h00,8'h00,1'b0,8'h5a},
    '{FIK_READ_BYTE,1'b0,1'b0,16'h0112,8'h00,8'h00,1'b0,8'ha5},
    '{FIK_MASS_ERASE,1'b0,1'b0,16'h0000,8'h54,8'h00,1'b1,8'h00},
    '{FIK_BLOCK_WRITE,1'b0,1'b0,16'h0000,8'h00,8'h11,1'b1,8'h00},
    '{FIK_BLOCK_WRITE,1'b0,1'b0,16'h0020,8'h00,8'h10,1'b0,8'h00},
    '{FIK_BLOCK_WRITE,1'b0,1'b0,16'h001e,8'h00,8'h04,1'b1,8'h00},
    '{FIK_BLOCK_READ,1'b0,1'b0,16'h0012,8'h00,8'h02,1'b0,8'h00},
    '{FIK_READ_BYTE,1'b1,1'b1,16'h0012,8'h00,8'h00,1'b1,8'h00},
    '{FIK_RD_OPTION,1'b1,1'b1,16'h0000,8'h00,8'h00,1'b0,8'h3c},
    '{FIK_WR_TIMING,1'b1,1'b1,16'h0000,8'h07,8'h00,1'b0,8'h00},
    '{FIK_READ_BYTE,1'b0,1'b1,16'h0012,8'h00,8'h00,1'b0,8'h5a}
  };
  logic        clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        security_bit;
  logic        security_b;
  logic        irq_en;
  logic [3:0]  irq_src_b;
  logic        fl_req;
  fik_cmd_type fl_op;
  logic [15:0] fl_addr;
  logic [7:0]  fl_wdata;
  logic [7:0]  fl_timing;
  logic        wdog_service;
  logic        wdog_lower_en;
  logic        fl_req_b;
  logic [15:0] fl_addr_b;
  logic [7:0]  mem [0:65535];
  int          num_errors = 0;
  int          checked = 0;
  int          wd_pulses = 0;

  fik_if lnk (.clk(clk));
  fik_if lnk_b (.clk(clk));
  fik_core i_fik_core (.clk(clk), .nrst(nrst), .lnk(lnk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // Level request while busy: repeats from one source must collapse to one
  fik_gate i_fik_gate (.clk(clk), .nrst(nrst), .lnk(lnk), .security_bit(security_bit),
    .option_value(8'h3c), .irq_src({3'h0, irq_en & lnk.busy}), .fl_req(fl_req),
    .fl_op(fl_op), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_timing(fl_timing),
    .fl_rdata(mem[fl_addr]), .fl_ack(fl_req), .wdog_service(wdog_service),
    .wdog_lower_en(wdog_lower_en));
  fik_gate i_fik_gate_b (.clk(clk), .nrst(nrst), .lnk(lnk_b), .security_bit(security_b),
    .option_value(8'h00), .irq_src(irq_src_b), .fl_req(fl_req_b), .fl_op(),
    .fl_addr(fl_addr_b), .fl_wdata(), .fl_timing(), .fl_rdata(fl_addr_b[7:0]),
    .fl_ack(fl_req_b), .wdog_service(), .wdog_lower_en());
  fik_checker chk_link (.clk(clk), .nrst(nrst), .reg_we(lnk.reg_we), .reg_addr(lnk.reg_addr),
    .reg_wdata(lnk.reg_wdata), .call(lnk.call), .call_cmd(lnk.call_cmd), .acc(lnk.acc),
    .from_loader(lnk.from_loader), .global_irq_enable(lnk.global_irq_enable), .busy(lnk.busy), .refused(lnk.refused),
    .irq_take(lnk.irq_take));

  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (fl_req && fl_op == FIK_WRITE_BYTE) mem[fl_addr] <= fl_wdata;
    if (wdog_service === 1'b1) wd_pulses <= wd_pulses + 1;
  end

  task automatic finish_test;
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic fail_wait;
    num_errors++;
    finish_test();
  endtask : fail_wait

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) fail_wait();
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic run_row(input fik_row_type r);
    logic [31:0] q;
    logic        e;
    int          n;
    security_bit <= r.sec;
    apb(1'b1, APB_ADDR, {16'h0, r.addr}, q, e);
    apb(1'b1, APB_WDATA, {24'h0, r.wd}, q, e);
    apb(1'b1, APB_COUNT, {24'h0, r.cnt}, q, e);
    apb(1'b1, APB_TIMING, 32'h07, q, e);
    apb(1'b1, APB_CTRL, {16'h0, r.wd, 4'h0, r.ldr, r.cmd}, q, e);
    n = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0, q, e);
      n++;
    end while (q[2:1] === 2'b00 && n < 100);
    if (n == 100) fail_wait();
    check("refused", {31'h0, q[STAT_REFUSED]}, {31'h0, r.refd});
    if (r.rd != 8'h00) check("read data", {24'h0, q[23:16]}, {24'h0, r.rd});
    apb(1'b1, APB_STATUS, 32'h6, q, e);
  endtask : run_row

  task automatic g2_try(input int gap, input logic [7:0] key, input logic irq, input logic exp);
    logic seen;
    int   n;
    seen = 1'b0;
    @(posedge clk);
    lnk_b.reg_we    <= 1'b1;
    lnk_b.reg_addr  <= OFS_UNLOCK;
    lnk_b.reg_wdata <= key;
    lnk_b.global_irq_enable       <= irq;
    irq_src_b       <= {2'h0, irq, 1'b0};
    @(posedge clk);
    lnk_b.reg_we <= 1'b0;
    irq_src_b    <= 4'h0;
    repeat (gap - 1) @(posedge clk);
    lnk_b.call <= 1'b1;
    @(posedge clk);
    lnk_b.call <= 1'b0;
    for (n = 0; n < 3; n++) begin
      @(posedge clk);
      seen = seen | lnk_b.refused;
    end
    for (n = 0; n < 300 && lnk_b.busy !== 1'b0; n++) @(posedge clk);
    if (n == 300) fail_wait();
    check("gate b refusal", {31'h0, seen}, {31'h0, exp});
  endtask : g2_try

  initial begin
    logic [31:0] q;
    logic        e;
    clk = 1'b0;
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {security_bit, security_b, irq_en, irq_src_b} = '0;
    {lnk_b.reg_we, lnk_b.reg_addr, lnk_b.reg_wdata, lnk_b.call, lnk_b.acc} = '0;
    {lnk_b.from_loader, lnk_b.global_irq_enable, lnk_b.ram_rdata} = '0;
    lnk_b.call_cmd = FIK_READ_BYTE;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, APB_STATUS, 32'h0, q, e);
    check("status at reset", q, 32'h0);
    apb(1'b0, 8'h30, 32'h0, q, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("lower window at reset", {31'h0, wdog_lower_en}, 32'h0);
    foreach (ROWS[i]) run_row(ROWS[i]);
    check("lower window", {31'h0, wdog_lower_en}, 32'h1);
    check("service pulses", {31'h0, wd_pulses > 0}, 32'h1);
    check("flash timing", {24'h0, fl_timing}, 32'h07);
    apb(1'b0, APB_BUF, 32'h0, q, e);
    check("block read slot 0", q, 32'h5a);
    apb(1'b1, APB_GIE, 32'h1, q, e);
    irq_en <= 1'b1;
    run_row(ROWS[2]);
    irq_en <= 1'b0;
    apb(1'b0, APB_STATUS, 32'h0, q, e);
    check("irq count", {24'h0, q[15:8]}, 32'h1);
    security_b <= 1'b1;
    g2_try(6, KEY_VALUE, 1'b0, 1'b0);
    // A second call on the spent key must be turned away
    @(posedge clk);
    lnk_b.call <= 1'b1;
    @(posedge clk);
    lnk_b.call <= 1'b0;
    @(posedge clk);
    check("second call refused", {31'h0, lnk_b.refused}, 32'h1);
    g2_try(7, KEY_VALUE, 1'b0, 1'b1);
    g2_try(2, 8'h97, 1'b0, 1'b1);
    g2_try(5, KEY_VALUE, 1'b1, 1'b1);
    finish_test();
  end
endmodule : flash_isp_key_gate_bench
